// *** design/slrs_status_bank.sv ***
// Link status and control register bank with two remote alias decoders.
// Assumes all inputs are synchronous to mclk; event inputs are one-cycle pulses.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "slrs_params.svh"
module slrs_status_bank (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    input  wire slrs_pkg::slrs_host_req_s host_req,
    input  wire logic [1:0][6:0]          target_addr,
    output slrs_pkg::slrs_fwd_s           fwd,
    input  wire logic                     fuse_load_done,
    input  wire logic                     fuse_checksum_valid,
    input  wire logic                     remote_lock,
    input  wire logic                     pll_locked,
    input  wire logic                     bc_link_valid,
    input  wire logic                     bc_error,
    input  wire logic                     bist_mode,
    input  wire logic                     bist_error,
    input  wire logic [3:0]               pin_level,
    input  wire slrs_pkg::slrs_alarm_s    alarm_in,
    output logic [2:0]                    link_detect_timer_value
);
    slrs_pkg::slrs_state_s st;
    slrs_pkg::slrs_state_s next_st;
    logic [1:0][7:0]       alias_regs;
    logic [1:0]            hits;
    slrs_pkg::slrs_fwd_s   fwds [2];
    logic                  wr_ctrl;
    logic                  rd_ctrl;
    logic                  selftest_clr;
    logic                  bc_err_clr;
    logic                  lost_change;

    assign alias_regs = {st.alias_seven, st.alias_six};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_alias
            slrs_alias_decode u_dec (
                .alias_entry (alias_regs[gi]),
                .target_addr (target_addr[gi]),
                .host_req    (host_req),
                .hit         (hits[gi]),
                .fwd         (fwds[gi])
            );
        end
    endgenerate

    always_comb begin
        next_st = st;
        wr_ctrl = reg_wr && (reg_addr == `SLRS_OFF_BC_CONTROL);
        rd_ctrl = reg_rd && (reg_addr == `SLRS_OFF_BC_CONTROL);
        selftest_clr = wr_ctrl && reg_wdata[`SLRS_BIT_SELFTEST_CLR];
        bc_err_clr   = wr_ctrl && reg_wdata[`SLRS_BIT_BC_ERR_CLR];
        lost_change  = (bc_link_valid != st.backchannel_link_valid);

        // Entry six wins when both aliases are programmed alike
        if (hits[0]) begin
            next_st.fwd = fwds[0];
        end else if (hits[1]) begin
            next_st.fwd = fwds[1];
        end else begin
            next_st.fwd = '0;
        end

        if (reg_wr && (reg_addr == `SLRS_OFF_ALIAS_SIX)) begin
            next_st.alias_six = reg_wdata;
        end
        if (reg_wr && (reg_addr == `SLRS_OFF_ALIAS_SEVEN)) begin
            next_st.alias_seven = reg_wdata;
        end
        // Clear strobes read back as one for a single cycle only
        next_st.selftest_error_counter_clear = selftest_clr;
        next_st.backchannel_error_clear      = bc_err_clr;
        if (wr_ctrl) begin
            next_st.ctrl_spare              = reg_wdata[`SLRS_BIT_CTRL_SPARE];
            next_st.link_detect_timer_value = reg_wdata[2:0];
        end

        case (st.init_state)
            slrs_pkg::SLRS_INIT_LOAD: begin
                if (fuse_load_done) begin
                    next_st.init_state         = slrs_pkg::SLRS_INIT_DONE;
                    next_st.config_checksum_ok = fuse_checksum_valid;
                end
            end
            slrs_pkg::SLRS_INIT_DONE: begin
                next_st.init_state = slrs_pkg::SLRS_INIT_DONE;
            end
            default: begin
                next_st.init_state = slrs_pkg::SLRS_INIT_LOAD;
            end
        endcase

        next_st.rx_lock                = remote_lock;
        next_st.forward_pll_locked     = pll_locked;
        next_st.backchannel_link_valid = bc_link_valid;
        next_st.pin_level_bits         = pin_level;

        // Set wins over clear for every sticky flag
        if (rd_ctrl || !pll_locked) begin
            next_st.link_lost = 1'b0;
        end
        if (lost_change) begin
            next_st.link_lost = 1'b1;
        end
        if (rd_ctrl || bc_err_clr) begin
            next_st.crc_error_seen = 1'b0;
        end
        if (bc_error && st.backchannel_link_valid) begin
            next_st.crc_error_seen = 1'b1;
        end

        if (selftest_clr) begin
            next_st.selftest_error_tally = 8'h00;
            next_st.selftest_error_seen  = 1'b0;
        end
        if (bist_mode && bist_error) begin
            next_st.selftest_error_seen = 1'b1;
            if (selftest_clr) begin
                next_st.selftest_error_tally = 8'h01;
            end else if (st.selftest_error_tally != 8'hff) begin
                next_st.selftest_error_tally = st.selftest_error_tally + 8'h01;
            end
        end

        if (bc_err_clr) begin
            next_st.checksum_error_tally = 16'h0000;
        end
        if (bc_error) begin
            if (bc_err_clr) begin
                next_st.checksum_error_tally = 16'h0001;
            end else if (st.checksum_error_tally != 16'hffff) begin
                next_st.checksum_error_tally = st.checksum_error_tally + 16'h0001;
            end
        end

        if (reg_rd && (reg_addr == `SLRS_OFF_ALARM_FLAGS)) begin
            next_st.alarm = '0;
        end
        next_st.alarm = next_st.alarm | alarm_in;

        next_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `SLRS_OFF_ALIAS_SIX:      next_st.rdata = st.alias_six;
                `SLRS_OFF_ALIAS_SEVEN:    next_st.rdata = st.alias_seven;
                `SLRS_OFF_BC_CONTROL:     next_st.rdata = {2'b00, st.selftest_error_counter_clear, st.ctrl_spare,
                                                           st.backchannel_error_clear, st.link_detect_timer_value};
                `SLRS_OFF_VERSION:        next_st.rdata = {`SLRS_REVISION_CODE, `SLRS_MASK_CODE};
                `SLRS_OFF_INIT_STATUS:    next_st.rdata = {st.config_checksum_ok,
                                                           (st.init_state == slrs_pkg::SLRS_INIT_DONE), 6'h00};
                `SLRS_OFF_GENERAL_STATUS: next_st.rdata = {1'b0, st.rx_lock, 1'b0, st.link_lost,
                                                           st.selftest_error_seen, st.forward_pll_locked,
                                                           st.crc_error_seen, st.backchannel_link_valid};
                `SLRS_OFF_PIN_LEVEL:      next_st.rdata = {4'h0, st.pin_level_bits};
                `SLRS_OFF_SELFTEST_COUNT: next_st.rdata = st.selftest_error_tally;
                `SLRS_OFF_CHECKSUM_LOW:   next_st.rdata = st.checksum_error_tally[7:0];
                `SLRS_OFF_CHECKSUM_HIGH:  next_st.rdata = st.checksum_error_tally[15:8];
                `SLRS_OFF_ALARM_FLAGS:    next_st.rdata = {2'b00, st.alarm};
                default:                  next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st                         <= '0;
            st.alias_six               <= `SLRS_RST_ALIAS;
            st.alias_seven             <= `SLRS_RST_ALIAS;
            st.link_detect_timer_value <= `SLRS_RST_TIMER;
            st.init_state              <= slrs_pkg::SLRS_INIT_LOAD;
            st.forward_pll_locked      <= `SLRS_RST_PLL_LOCKED;
            st.backchannel_link_valid  <= `SLRS_RST_LINK_VALID;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata               = st.rdata;
    assign fwd                     = st.fwd;
    assign link_detect_timer_value = st.link_detect_timer_value;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    alias_zero_block_a: assert property (
        (st.alias_six[7:1] == 7'h00 && st.alias_seven[7:1] == 7'h00) |=> !fwd.valid)
        else $error("forward issued with both aliases disabled");

    alias_remap_a: assert property (
        (host_req.valid && st.alias_six[7:1] != 7'h00 && host_req.addr == st.alias_six[7:1])
        |=> (fwd.valid && fwd.addr == $past(target_addr[0])))
        else $error("alias six hit not remapped to its target");

    auto_ack_a: assert property (
        (host_req.valid && host_req.is_write && st.alias_six[7:1] != 7'h00 && st.alias_six[0]
         && host_req.addr == st.alias_six[7:1]) |=> fwd.ack)
        else $error("auto acknowledge missing on write");

    selftest_clear_a: assert property (
        (wr_ctrl && reg_wdata[`SLRS_BIT_SELFTEST_CLR] && !bist_error)
        |=> (st.selftest_error_tally == 8'h00 && st.selftest_error_counter_clear)
            ##1 !st.selftest_error_counter_clear || $past(selftest_clr))
        else $error("selftest counter clear or self-clear failed");

    bc_clear_a: assert property (
        (wr_ctrl && !reg_wdata[`SLRS_BIT_BC_ERR_CLR] && !bc_error)
        |=> st.checksum_error_tally == $past(st.checksum_error_tally))
        else $error("writing zero changed the error count");

    timer_store_a: assert property (
        wr_ctrl |=> link_detect_timer_value == $past(reg_wdata[2:0]))
        else $error("link detect timer value not stored");

    init_done_a: assert property (
        (st.init_state == slrs_pkg::SLRS_INIT_LOAD && fuse_load_done)
        |=> (st.init_state == slrs_pkg::SLRS_INIT_DONE && st.config_checksum_ok == $past(fuse_checksum_valid)))
        else $error("init completion or checksum status wrong");

    link_lost_set_a: assert property (
        (bc_link_valid != st.backchannel_link_valid) |=> st.link_lost [*1] ##1 1'b1)
        else $error("link lost change not flagged");

    crc_flag_a: assert property (
        (st.crc_error_seen && rd_ctrl && !bc_error) |=> !st.crc_error_seen)
        else $error("error flag not cleared by control read");

    alarm_read_a: assert property (
        (reg_rd && reg_addr == `SLRS_OFF_ALARM_FLAGS && alarm_in == '0)
        |=> (st.alarm == '0 && reg_rdata[5:0] == $past(st.alarm)))
        else $error("alarm flags not returned and cleared on read");

    saturate_a: assert property (
        (st.checksum_error_tally == 16'hffff && !bc_err_clr) |=> st.checksum_error_tally == 16'hffff)
        else $error("error count wrapped");

    // The wide count cannot reach its limit in a short run; the narrow one can
    selftest_sat_a: assert property (
        (st.selftest_error_tally == 8'hff && !selftest_clr) |=> st.selftest_error_tally == 8'hff)
        else $error("selftest count wrapped");

    pll_reflect_a: assert property (
        reg_rd && reg_addr == `SLRS_OFF_GENERAL_STATUS |=> reg_rdata[2] == $past(st.forward_pll_locked))
        else $error("pll lock bit misreported");

    remap_seen_c: cover property (host_req.valid ##1 fwd.valid);
    count_clear_c: cover property (bc_error ##[1:20] (wr_ctrl && reg_wdata[`SLRS_BIT_BC_ERR_CLR]));
    alarm_clear_c: cover property (alarm_in != '0 ##[1:20] (reg_rd && reg_addr == `SLRS_OFF_ALARM_FLAGS));
    init_finish_c: cover property (st.init_state == slrs_pkg::SLRS_INIT_DONE && st.config_checksum_ok);
endmodule

// *** design/slrs_params.svh ***
// Offsets, field positions, reset values and identity constants of the link status register bank.
// Assumes an 8-bit register port with one-cycle strobes; included by the bank and its decoder.
//
// Behaviour
// - Alias entries hold a 7-bit address in 7:1; matches remap to target address.
// - Alias field zero disables forwarding to that remote target; reset is zero.
// - Auto-acknowledge bit 0 acknowledges every write regardless of lock or remote ack.
// - Writing 1 to control bit 5 clears selftest error counter; self-clears.
// - Writing 1 to control bit 3 clears back-channel error state; self-clears.
// - Control bits 2:0 hold the link detect timer value, reset zero.
// - Init status bit 7 set after init only if fuse checksum valid.
// - Init status bit 6 set once power-up fuse load has finished.
// - General status bit 6 mirrors remote deserializer forward lock.
// - Bit 4 set on link-lost change; cleared by control read or PLL unlock.
// - Bit 3 flags selftest error; selftest counter holds their number.
// - Bit 2 reports forward PLL lock, reset value one.
// - Bit 1 set on back-channel error while link valid; cleared by control read.
// - Bit 0 high while back-channel link valid, reset value one.
// - Pin readback bits 3:0 return present level of pins 3..0.
// - Eight-bit read-only selftest error count at offset 0x54.
// - Sixteen-bit error count, low byte 0x55, high byte 0x56.
// - Alarm bits 5 and 4 flag temperature over/under limit; clear on read.
// - Alarm bits 3 and 2 flag pin1 voltage over/under limit; clear on read.
// - Alarm bits 1 and 0 flag pin0 voltage over/under limit; clear on read.
`ifndef SLRS_PARAMS_SVH
`define SLRS_PARAMS_SVH

`define SLRS_OFF_ALIAS_SIX      8'h47
`define SLRS_OFF_ALIAS_SEVEN    8'h48
`define SLRS_OFF_BC_CONTROL     8'h49
`define SLRS_OFF_VERSION        8'h50
`define SLRS_OFF_INIT_STATUS    8'h51
`define SLRS_OFF_GENERAL_STATUS 8'h52
`define SLRS_OFF_PIN_LEVEL      8'h53
`define SLRS_OFF_SELFTEST_COUNT 8'h54
`define SLRS_OFF_CHECKSUM_LOW   8'h55
`define SLRS_OFF_CHECKSUM_HIGH  8'h56
`define SLRS_OFF_ALARM_FLAGS    8'h57

`define SLRS_BIT_SELFTEST_CLR   5
`define SLRS_BIT_CTRL_SPARE     4
`define SLRS_BIT_BC_ERR_CLR     3
`define SLRS_AUTO_ACK_BIT       0

`define SLRS_RST_ALIAS          8'h00
`define SLRS_RST_TIMER          3'h0
`define SLRS_RST_PLL_LOCKED     1'b1
`define SLRS_RST_LINK_VALID     1'b1

// Arbitrary neutral identity codes
`define SLRS_REVISION_CODE      4'h5
`define SLRS_MASK_CODE          4'ha

`endif

// *** design/slrs_pkg.sv ***
// Types shared by the link status register bank and its alias decoder.
// Assumes the constants header is included by the users of these types.
package slrs_pkg;

    typedef enum logic [1:0] {
        SLRS_INIT_LOAD = 2'b01,
        SLRS_INIT_DONE = 2'b10
    } slrs_init_e;

    typedef struct packed {
        logic       valid;
        logic       is_write;
        logic       remote_ack;
        logic [6:0] addr;
    } slrs_host_req_s;

    typedef struct packed {
        logic       valid;
        logic       ack;
        logic [6:0] addr;
    } slrs_fwd_s;

    typedef struct packed {
        logic temperature_over_limit;
        logic temperature_under_limit;
        logic pin1_voltage_over_limit;
        logic pin1_voltage_under_limit;
        logic pin0_voltage_over_limit;
        logic pin0_voltage_under_limit;
    } slrs_alarm_s;

    typedef struct packed {
        logic [7:0]  alias_six;
        logic [7:0]  alias_seven;
        logic        ctrl_spare;
        logic [2:0]  link_detect_timer_value;
        logic        selftest_error_counter_clear;
        logic        backchannel_error_clear;
        slrs_init_e  init_state;
        logic        config_checksum_ok;
        logic        rx_lock;
        logic        forward_pll_locked;
        logic        backchannel_link_valid;
        logic        link_lost;
        logic        crc_error_seen;
        logic        selftest_error_seen;
        logic [3:0]  pin_level_bits;
        logic [7:0]  selftest_error_tally;
        logic [15:0] checksum_error_tally;
        slrs_alarm_s alarm;
        logic [7:0]  rdata;
        slrs_fwd_s   fwd;
    } slrs_state_s;

endpackage

// *** design/slrs_alias_decode.sv ***
// One remote target alias decoder: compares a host address with an alias entry.
// Assumes the host request is synchronous to the bank clock; purely combinational.
`timescale 1ns/1ps
`include "slrs_params.svh"
module slrs_alias_decode (
    input  wire logic [7:0]              alias_entry,
    input  wire logic [6:0]              target_addr,
    input  wire slrs_pkg::slrs_host_req_s host_req,
    output logic                         hit,
    output slrs_pkg::slrs_fwd_s          fwd
);
    logic enabled;

    always_comb begin
        enabled  = (alias_entry[7:1] != 7'h00);
        hit      = host_req.valid && enabled && (host_req.addr == alias_entry[7:1]);
        fwd.valid = hit;
        fwd.addr  = target_addr;
        // Debug mode: a write is acknowledged locally even with no lock
        fwd.ack   = hit && ((host_req.is_write && alias_entry[`SLRS_AUTO_ACK_BIT])
                            || host_req.remote_ack);
    end
endmodule

// *** verification/slrs_remote_model.sv ***
// Behavioural remote deserializer: forward lock, back-channel link and CRC error pulses.
// Assumes the bench calls its tasks just after a rising mclk edge.
`timescale 1ns/1ps
module slrs_remote_model (
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      remote_lock,
    output logic      bc_link_valid,
    output logic      bc_error,
    output logic      remote_ack
);
    // A remote end only acknowledges while it holds lock, so an unlocked link never acks
    assign remote_ack = remote_lock & rst_n;
    initial begin
        remote_lock   = 1'b0;
        bc_link_valid = 1'b1;
        bc_error      = 1'b0;
    end
    task automatic set_link(input logic lock, input logic link);
        remote_lock   <= lock;
        bc_link_valid <= link;
    endtask
    // Pulses are spaced by an idle cycle, as errors arrive one frame apart
    task automatic send_errors(input int n);
        repeat (n) begin
            bc_error <= 1'b1;
            @(posedge mclk);
            bc_error <= 1'b0;
            @(posedge mclk);
        end
    endtask
endmodule

// *** verification/slrs_status_bank_tb_top.sv ***
// Self-checking bench of the link status register bank with a remote deserializer model.
// Assumes a 125 MHz mclk and a synchronous active-low reset.
`timescale 1ns/1ps
`include "slrs_params.svh"
module slrs_status_bank_tb_top;
    logic                     mclk;
    logic                     rst_n;
    logic [7:0]               reg_addr;
    logic [7:0]               reg_wdata;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [7:0]               reg_rdata;
    slrs_pkg::slrs_host_req_s host_req;
    logic                     h_valid;
    logic                     h_write;
    logic [6:0]               h_addr;
    logic [1:0][6:0]          target_addr;
    slrs_pkg::slrs_fwd_s      fwd;
    logic                     fuse_load_done;
    logic                     fuse_checksum_valid;
    logic                     remote_lock;
    logic                     pll_locked;
    logic                     bc_link_valid;
    logic                     bc_error;
    logic                     remote_ack;
    logic                     bist_mode;
    logic                     bist_error;
    logic [3:0]               pin_level;
    slrs_pkg::slrs_alarm_s    alarm_in;
    logic [2:0]               timer;
    int                       fails = 0;
    int                       n_tests = 0;
    logic [7:0]               v;
    logic [7:0]               a6;
    logic [7:0]               offs [13] = '{8'h47, 8'h48, 8'h49, 8'h50, 8'h51, 8'h52, 8'h53,
                                            8'h54, 8'h55, 8'h56, 8'h57, 8'h40, 8'h4a};
    logic [7:0]               rst_exp [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00,
                                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    assign host_req = '{h_valid, h_write, remote_ack, h_addr};

    slrs_status_bank i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_req(host_req),
        .target_addr(target_addr), .fwd(fwd), .fuse_load_done(fuse_load_done),
        .fuse_checksum_valid(fuse_checksum_valid), .remote_lock(remote_lock), .pll_locked(pll_locked),
        .bc_link_valid(bc_link_valid), .bc_error(bc_error), .bist_mode(bist_mode),
        .bist_error(bist_error), .pin_level(pin_level), .alarm_in(alarm_in),
        .link_detect_timer_value(timer));
    slrs_remote_model i_remote (.mclk(mclk), .rst_n(rst_n), .remote_lock(remote_lock),
        .bc_link_valid(bc_link_valid), .bc_error(bc_error), .remote_ack(remote_ack));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Every driver task starts just after a rising edge and leaves just after one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
        @(posedge mclk);
    endtask
    task automatic host(input logic [6:0] a, input logic w, output slrs_pkg::slrs_fwd_s f);
        h_addr  <= a;
        h_write <= w;
        h_valid <= 1'b1;
        @(posedge mclk);
        h_valid <= 1'b0;
        #1 f = fwd;
        @(posedge mclk);
    endtask
    task automatic bist_pulses(input int n);
        repeat (n) begin
            bist_error <= 1'b1;
            @(posedge mclk);
            bist_error <= 1'b0;
            @(posedge mclk);
        end
        @(posedge mclk);
    endtask
    task automatic do_reset(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #400000;
        fails++;
        print_verdict();
    end

    initial begin
        slrs_pkg::slrs_fwd_s f;
        int                  k;
        rst_n = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, h_valid, h_write, h_addr} = '0;
        {fuse_load_done, fuse_checksum_valid, bist_mode, bist_error} = '0;
        pll_locked = 1'b1;
        alarm_in   = '0;
        void'($urandom(36657));
        pin_level   = 4'($urandom);
        target_addr = 14'($urandom);
        rst_exp[3]  = {`SLRS_REVISION_CODE, `SLRS_MASK_CODE};
        rst_exp[6]  = {4'h0, pin_level};
        do_reset(20);
        for (k = 0; k < 13; k++) begin
            rd_chk(offs[k], rst_exp[k]);
        end
        // Both aliases share one address, so entry six must win
        a6 = {7'($urandom_range(127, 1)), 1'b1};
        wr(8'h47, a6);
        wr(8'h48, {a6[7:1], 1'b0});
        wr(8'h54, 8'hff);
        rd_chk(8'h47, a6);
        rd_chk(8'h48, {a6[7:1], 1'b0});
        rd_chk(8'h54, 8'h00);
        host(a6[7:1], 1'b1, f);
        check(f, {1'b1, 1'b1, target_addr[0]});
        host(a6[7:1], 1'b0, f);
        check(f, {1'b1, 1'b0, target_addr[0]});
        wr(8'h47, 8'h00);
        i_remote.set_link(1'b1, 1'b1);
        host(a6[7:1], 1'b0, f);
        check(f, {1'b1, 1'b1, target_addr[1]});
        wr(8'h48, 8'h00);
        host(a6[7:1], 1'b1, f);
        check(f.valid, 1'b0);
        rd_chk(8'h52, 8'h45);
        pll_locked <= 1'b0;
        @(posedge mclk);
        rd_chk(8'h52, 8'h41);
        pll_locked <= 1'b1;
        k = 256 + $urandom_range(40);
        i_remote.send_errors(k);
        @(posedge mclk);
        rd_chk(8'h55, 8'(k));
        rd_chk(8'h56, 8'h01);
        rd_chk(8'h52, 8'h47);
        i_remote.set_link(1'b1, 1'b0);
        repeat (2) @(posedge mclk);
        rd_chk(8'h52, 8'h56);
        i_remote.set_link(1'b1, 1'b1);
        repeat (2) @(posedge mclk);
        rd_chk(8'h49, 8'h00);
        rd_chk(8'h52, 8'h45);
        wr(8'h49, 8'h08);
        rd_chk(8'h49, 8'h00);
        rd_chk(8'h55, 8'h00);
        rd_chk(8'h56, 8'h00);
        // Errors outside self-test mode are not counted
        bist_pulses(3);
        bist_mode <= 1'b1;
        bist_pulses(260);
        rd_chk(8'h54, 8'hff);
        rd_chk(8'h52, 8'h4d);
        wr(8'h49, 8'h20);
        rd_chk(8'h54, 8'h00);
        rd_chk(8'h52, 8'h45);
        v = 8'($urandom) & 8'h17;
        wr(8'h49, v);
        check(timer, v[2:0]);
        rd_chk(8'h49, v);
        v = 8'($urandom_range(63, 1));
        alarm_in  <= v[5:0];
        pin_level <= ~pin_level;
        @(posedge mclk);
        alarm_in <= '0;
        @(posedge mclk);
        rd_chk(8'h57, v);
        rd_chk(8'h57, 8'h00);
        rd_chk(8'h53, {4'h0, pin_level});
        for (k = 0; k < 2; k++) begin
            do_reset(2);
            rd_chk(8'h47, 8'h00);
            rd_chk(8'h51, 8'h00);
            fuse_checksum_valid <= k[0];
            fuse_load_done      <= 1'b1;
            @(posedge mclk);
            fuse_load_done <= 1'b0;
            @(posedge mclk);
            rd_chk(8'h51, {k[0], 7'h40});
        end
        print_verdict();
    end
endmodule
